/* File: logic/flash_ctrl_consts.svh */
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

// operation select codes
`define OP_STANDBY 8'h00
`define OP_READ 8'h01
`define OP_PROGRAM 8'h02
`define OP_ERASE 8'h03
// trigger bytes
`define TRIG_FIRST 8'h46
`define TRIG_SECOND 8'hB9
// access control fields
`define ACC_EN_BIT 7
`define ACC_RST_HI 7
`define ACC_RST_LO 5
`define RST_TO_APP 3'h1
`define RST_TO_APP_ALT 3'h5
`define RST_TO_LOADER 3'h7
// page geometry: 512 bytes, offset bits 8..0
`define PAGE_OFS_BITS 9
// register reset values
`define DATA_PORT_RESET 8'hFF
`define CTRL_REG_RESET 8'h00
`define APP_START_ADDR 16'h0000
// flash busy time per operation, in ns and in cycles at 4 ns
`define CLK_PERIOD_NS 4
`define OP_TIME_NS 64
`define OP_CYCLES ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: logic/flash_ctrl_pkg.sv */
`default_nettype none
package flash_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } seq_state_t;
    typedef logic [15:0] flash_addr_t;
    typedef logic [7:0] flash_byte_t;
endpackage
`default_nettype wire

/* File: logic/flash_array_if.sv */
`default_nettype none
interface flash_array_if;
    import flash_ctrl_pkg::*;
    logic rd;
    logic wr;
    logic erase;
    flash_addr_t addr;
    flash_byte_t wdata;
    flash_byte_t rdata;
    modport ctrl (output rd, output wr, output erase, output addr,
        output wdata, input rdata);
    modport mem (input rd, input wr, input erase, input addr,
        input wdata, output rdata);
endinterface
`default_nettype wire

/* File: logic/flash_array.sv */
`include "flash_ctrl_consts.svh"
`default_nettype none
module flash_array (
    input wire logic clk,
    flash_array_if.mem port
);
    import flash_ctrl_pkg::*;

    flash_byte_t cells [0:65535];
    logic [15:0] page_base;
    assign page_base = {port.addr[15:`PAGE_OFS_BITS],
        {`PAGE_OFS_BITS{1'b0}}};

    // cell array: program clears bits only, erase sets a page to ones
    always_ff @(posedge clk) begin
        if (port.wr) begin
            cells[port.addr] <= cells[port.addr] & port.wdata;
        end
        if (port.erase) begin
            for (int i = 0; i < 512; i++) begin
                cells[page_base + 16'(i)] <= 8'hFF;
            end
        end
    end

    // read data, registered
    always_ff @(posedge clk) begin
        if (port.rd) begin
            port.rdata <= cells[port.addr];
        end
    end
endmodule
`default_nettype wire

/* File: logic/sync2.sv */
`default_nettype none
module sync2 (
    input wire logic clk,
    input wire logic nrst,
    input wire logic d,
    output logic q
);
    logic meta;
    // two-stage synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: logic/flash_self_programming_ctrl.sv */
// Notes on behaviour
// - programming can only clear bits; setting a bit needs an erase
// - erase works per page and sets every bit of it to one
// - a page is 512 bytes, aligned with address bits 8..0 zero
// - target address is high register above low register
// - byte program writes the data port into the addressed byte
// - byte read puts the addressed byte into the data port
// - cpu is frozen during an operation, then resumes at next instruction
// - enabled interrupts raised while frozen are held, but only those still raised at completion remain
// - access control bits 7..5 = 001 resets into application at 0x0000
// - bits 7..5 = 101 resets and reboots from application memory
// - bits 7..5 = 111 from application resets into loader memory
// - with boot option and loader region, power-on boots the loader
// - with extra option, external reset also boots the loader
// - loader fetches are relocated by the loader start address
// - targets beyond the data region end are ignored
// - loader code may modify only application and data memory
// - op select: read 0x01, program 0x02, erase 0x03
// - start needs 0x46 then 0xB9 with access enabled and op selected
`include "flash_ctrl_consts.svh"
`default_nettype none
module flash_self_programming_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // cpu register writes (same clock)
    input wire logic access_ctrl_we,
    input wire flash_ctrl_pkg::flash_byte_t access_ctrl_wdata,
    input wire logic op_select_we,
    input wire flash_ctrl_pkg::flash_byte_t op_select_wdata,
    input wire logic addr_high_we,
    input wire logic addr_low_we,
    input wire logic data_port_we,
    input wire logic trigger_we,
    input wire flash_ctrl_pkg::flash_byte_t wdata,
    // register contents
    output flash_ctrl_pkg::flash_byte_t flash_access_control,
    output flash_ctrl_pkg::flash_byte_t flash_op_select,
    output flash_ctrl_pkg::flash_byte_t flash_addr_high,
    output flash_ctrl_pkg::flash_byte_t flash_addr_low,
    output flash_ctrl_pkg::flash_byte_t flash_data_port,
    // region configuration
    input wire flash_ctrl_pkg::flash_addr_t loader_start,
    input wire logic loader_region_en,
    input wire flash_ctrl_pkg::flash_addr_t data_region_low,
    input wire logic running_loader,
    input wire logic hw_loader_boot_option,
    input wire logic ext_reset_loader_boot_option,
    input wire logic power_on_boot,
    input wire logic ext_reset_boot,
    // cpu fetch relocation
    input wire flash_ctrl_pkg::flash_addr_t cpu_fetch_addr,
    output flash_ctrl_pkg::flash_addr_t phys_fetch_addr,
    // interrupts
    input wire logic [3:0] external_interrupt_inputs,
    input wire logic [3:0] irq_enable,
    output logic [3:0] irq_pending,
    // cpu control
    output logic cpu_freeze,
    output logic op_done,
    output logic op_rejected,
    output logic soft_reset,
    output logic boot_loader
);
    import flash_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    seq_state_t state;
    logic armed;
    logic [7:0] busy_cnt;
    flash_byte_t cur_op;
    flash_addr_t target;
    flash_addr_t region_end;
    logic target_ok;
    logic op_valid;
    logic launch;
    logic [3:0] ext_irq_sync;
    logic boot_sel;
    flash_array_if arr ();

    flash_array u_array (
        .clk(clk),
        .port(arr)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            sync2 u_sync (
                .clk(clk),
                .nrst(nrst),
                .d(external_interrupt_inputs[g]),
                .q(ext_irq_sync[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // address and legality
    assign target = {flash_addr_high, flash_addr_low};
    // last writable byte sits below the loader region when present
    assign region_end = loader_region_en ? loader_start - 16'h0001
                                         : 16'hFFFF;
    // loader code reaches application and data memory, application
    // code only the data region; nothing beyond the data region
    assign target_ok = (target <= region_end)
        && (running_loader || target >= data_region_low);
    assign op_valid = (flash_op_select == `OP_READ)
        || (flash_op_select == `OP_PROGRAM)
        || (flash_op_select == `OP_ERASE);
    // the second byte launches; a frozen cpu cannot trigger again
    assign launch = trigger_we && armed && (wdata == `TRIG_SECOND)
        && flash_access_control[`ACC_EN_BIT] && op_valid
        && state == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // access control register, bit 7 enables flash access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_access_control <= `CTRL_REG_RESET;
        end else if (access_ctrl_we) begin
            flash_access_control <= access_ctrl_wdata;
        end
    end

    // operation select register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_op_select <= `OP_STANDBY;
        end else if (op_select_we) begin
            flash_op_select <= op_select_wdata;
        end
    end

    // target address, high byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_addr_high <= `CTRL_REG_RESET;
        end else if (addr_high_we) begin
            flash_addr_high <= wdata;
        end
    end

    // target address, low byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_addr_low <= `CTRL_REG_RESET;
        end else if (addr_low_we) begin
            flash_addr_low <= wdata;
        end
    end

    // data port: cpu write, or read result on completion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_data_port <= `DATA_PORT_RESET;
        end else if (state == ST_DONE && cur_op == `OP_READ) begin
            flash_data_port <= arr.rdata;
            // the cpu is frozen, so no write competes here
        end else if (data_port_we) begin
            flash_data_port <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger sequence tracker
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (!flash_access_control[`ACC_EN_BIT]) begin
            // a pending first byte is dropped with the enable
            armed <= 1'b0;
        end else if (trigger_we) begin
            // any other byte breaks the pair
            armed <= (wdata == `TRIG_FIRST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            busy_cnt <= 8'h00;
            cur_op <= `OP_STANDBY;
            cpu_freeze <= 1'b0;
            op_done <= 1'b0;
            op_rejected <= 1'b0;
        end else begin
            op_done <= 1'b0;
            op_rejected <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (launch && target_ok) begin
                        state <= ST_BUSY;
                        cur_op <= flash_op_select;
                        busy_cnt <= 8'(`OP_CYCLES - 1);
                        cpu_freeze <= 1'b1;
                    end else if (launch) begin
                        op_rejected <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    // count out the flash busy time
                    if (busy_cnt == 8'h00) begin
                        state <= ST_DONE;
                    end else begin
                        busy_cnt <= busy_cnt - 8'h01;
                    end
                end
                ST_DONE: begin
                    // release the cpu, the result now stands
                    state <= ST_IDLE;
                    cpu_freeze <= 1'b0;
                    op_done <= 1'b1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // array strobes, one cycle at the start of the busy phase
    always_comb begin
        arr.addr = target;
        arr.wdata = flash_data_port;
        arr.wr = 1'b0;
        arr.erase = 1'b0;
        arr.rd = 1'b0;
        if (state == ST_BUSY && busy_cnt == 8'(`OP_CYCLES - 1)) begin
            arr.wr = (cur_op == `OP_PROGRAM);
            arr.erase = (cur_op == `OP_ERASE);
            arr.rd = (cur_op == `OP_READ);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt queue while frozen
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_pending <= 4'h0;
        end else begin
            // held while frozen; at completion only live requests remain
            irq_pending <= irq_enable & (ext_irq_sync
                | ((cpu_freeze && state != ST_DONE) ? irq_pending : 4'h0));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software reset and boot source
    always_comb begin
        boot_sel = 1'b0;
        if (hw_loader_boot_option && loader_region_en) begin
            boot_sel = power_on_boot
                || (ext_reset_boot && ext_reset_loader_boot_option);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            soft_reset <= 1'b0;
            boot_loader <= 1'b0;
        end else begin
            soft_reset <= 1'b0;
            // boot_sel is taken only on a hardware reset; software resets below set the source themselves
            if (power_on_boot || ext_reset_boot) begin
                boot_loader <= boot_sel;
            end
            if (access_ctrl_we) begin
                unique case (access_ctrl_wdata[`ACC_RST_HI:`ACC_RST_LO])
                    `RST_TO_APP, `RST_TO_APP_ALT: begin
                        soft_reset <= 1'b1;
                        boot_loader <= 1'b0;
                    end
                    `RST_TO_LOADER: begin
                        // only application code, only with a loader region
                        if (!running_loader && loader_region_en) begin
                            soft_reset <= 1'b1;
                            boot_loader <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // fetch relocation for loader code linked at zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phys_fetch_addr <= `APP_START_ADDR;
        end else begin
            phys_fetch_addr <= running_loader
                ? cpu_fetch_addr + loader_start
                : cpu_fetch_addr;
        end
    end
endmodule
`default_nettype wire

/* File: tb/flash_self_programming_ctrl_monitor.sv */
`default_nettype none
module flash_self_programming_ctrl_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register writes and contents
    input wire logic access_ctrl_we,
    input wire flash_ctrl_pkg::flash_byte_t access_ctrl_wdata,
    input wire logic trigger_we,
    input wire flash_ctrl_pkg::flash_byte_t wdata,
    input wire flash_ctrl_pkg::flash_byte_t flash_access_control,
    input wire flash_ctrl_pkg::flash_byte_t flash_op_select,
    input wire flash_ctrl_pkg::flash_byte_t flash_addr_high,
    input wire flash_ctrl_pkg::flash_byte_t flash_addr_low,
    // region and fetch
    input wire flash_ctrl_pkg::flash_addr_t loader_start,
    input wire logic loader_region_en,
    input wire logic running_loader,
    input wire flash_ctrl_pkg::flash_addr_t cpu_fetch_addr,
    input wire flash_ctrl_pkg::flash_addr_t phys_fetch_addr,
    // cpu control
    input wire logic cpu_freeze,
    input wire logic op_done,
    input wire logic soft_reset,
    input wire logic boot_loader
);
    timeunit 1ns;
    timeprecision 100ps;
    import flash_ctrl_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // launch and freeze timing
    launch_cause_a: assert property ($rose(cpu_freeze) |->
        $past(trigger_we) && $past(wdata) == 8'hB9 &&
        $past(flash_access_control[7]))
        else $error("freeze without a valid trigger");
    freeze_span_a: assert property ($rose(cpu_freeze) |->
        cpu_freeze[*8] ##10 (op_done && !cpu_freeze))
        else $error("freeze length or completion wrong");
    done_after_freeze_a: assert property (op_done |->
        !cpu_freeze && $past(cpu_freeze))
        else $error("done pulse outside an operation");
    ////////////////////////////////////////////////////////////////////////
    // triggers that must start nothing
    disabled_ignored_a: assert property (trigger_we &&
        !$past(trigger_we) && !cpu_freeze && !flash_access_control[7]
        |=> !cpu_freeze)
        else $error("launch with access disabled");
    bad_code_ignored_a: assert property (trigger_we &&
        !$past(trigger_we) && !cpu_freeze &&
        !(flash_op_select inside {8'h01, 8'h02, 8'h03}) |=> !cpu_freeze)
        else $error("launch with no operation selected");
    beyond_ignored_a: assert property (trigger_we &&
        !$past(trigger_we) && !cpu_freeze && loader_region_en &&
        {flash_addr_high, flash_addr_low} >= loader_start |=> !cpu_freeze)
        else $error("launch on a target beyond the data region");
    ////////////////////////////////////////////////////////////////////////
    // software reset, boot and relocation
    app_reset_a: assert property (access_ctrl_we &&
        access_ctrl_wdata[7:5] == 3'h1 |-> ##[1:2] soft_reset)
        else $error("no software reset for code 001");
    loader_reset_a: assert property (access_ctrl_we &&
        access_ctrl_wdata[7:5] == 3'h7 && !running_loader &&
        loader_region_en |-> ##[1:2] (soft_reset && boot_loader))
        else $error("no loader boot for code 111");
    fetch_reloc_a: assert property ($past(nrst) |->
        phys_fetch_addr == $past(cpu_fetch_addr) +
        ($past(running_loader) ? $past(loader_start) : 16'h0000))
        else $error("fetch address not relocated");
endmodule
bind flash_self_programming_ctrl flash_self_programming_ctrl_monitor
    i_flash_self_programming_ctrl_monitor (.clk(clk), .nrst(nrst),
    .access_ctrl_we(access_ctrl_we), .access_ctrl_wdata(access_ctrl_wdata),
    .trigger_we(trigger_we), .wdata(wdata),
    .flash_access_control(flash_access_control),
    .flash_op_select(flash_op_select), .flash_addr_high(flash_addr_high),
    .flash_addr_low(flash_addr_low), .loader_start(loader_start),
    .loader_region_en(loader_region_en), .running_loader(running_loader),
    .cpu_fetch_addr(cpu_fetch_addr), .phys_fetch_addr(phys_fetch_addr),
    .cpu_freeze(cpu_freeze), .op_done(op_done), .soft_reset(soft_reset),
    .boot_loader(boot_loader));
`default_nettype wire

/* File: tb/flash_self_programming_ctrl_tb_top.sv */
`default_nettype none
module flash_self_programming_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_ctrl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] we = '0;
    flash_byte_t d = '0;
    flash_byte_t r_acc, r_op, r_hi, r_lo, r_data;
    flash_addr_t fetch = '0;
    flash_addr_t phys;
    logic runld = 1'b1, hwopt = 1'b0, extopt = 1'b0, pob = 1'b0, erb = 1'b0;
    logic lden = 1'b1;
    logic [3:0] ext_irq = '0;
    logic [3:0] pend, irq_at;
    logic freeze, done, rej, srst, bootl, seen_done, seen_rej, seen;
    int num_errors = 0;
    int comparisons = 0;
    ////////////////////////////////////////////////////////////////////////
    // design under test
    flash_self_programming_ctrl i_flash_self_programming_ctrl (
        .clk(clk), .nrst(nrst), .access_ctrl_we(we[0]),
        .access_ctrl_wdata(d), .op_select_we(we[1]), .op_select_wdata(d),
        .addr_high_we(we[2]), .addr_low_we(we[3]), .data_port_we(we[4]),
        .trigger_we(we[5]), .wdata(d), .flash_access_control(r_acc),
        .flash_op_select(r_op), .flash_addr_high(r_hi),
        .flash_addr_low(r_lo), .flash_data_port(r_data),
        .loader_start(16'hFE00), .loader_region_en(lden),
        .data_region_low(16'hF000), .running_loader(runld),
        .hw_loader_boot_option(hwopt), .ext_reset_loader_boot_option(extopt),
        .power_on_boot(pob), .ext_reset_boot(erb), .cpu_fetch_addr(fetch),
        .phys_fetch_addr(phys), .external_interrupt_inputs(ext_irq),
        .irq_enable(4'h1), .irq_pending(pend), .cpu_freeze(freeze),
        .op_done(done), .op_rejected(rej), .soft_reset(srst),
        .boot_loader(bootl));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // compare, register write and access sequence tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic wr(input int k, input flash_byte_t v);
        @(posedge clk);
        we <= 6'h01 << k;
        d <= v;
        @(posedge clk);
        we <= '0;
    endtask
    // mid is a stray trigger byte between the two when nonzero
    task automatic op(input flash_byte_t en, input flash_byte_t code,
        input flash_addr_t a, input flash_byte_t v, input flash_byte_t mid);
        wr(0, en);
        wr(1, code);
        wr(2, a[15:8]);
        wr(3, a[7:0]);
        wr(4, v);
        wr(5, 8'h46);
        if (mid != 8'h00)
            wr(5, mid);
        wr(5, 8'hB9);
        seen_done = 1'b0;
        seen_rej = 1'b0;
        for (int i = 0; i < 30 && !seen_done; i++) begin
            #1;
            seen_done |= (done === 1'b1);
            seen_rej |= (rej === 1'b1);
            if (freeze === 1'b1)
                irq_at = pend;
            @(posedge clk);
            // a short request while frozen, dropped before completion
            ext_irq <= (i == 3) ? 4'h3 : (i == 6) ? 4'h0 : ext_irq;
        end
        #1 chk(pend, 4'h0);
        chk({r_hi, r_lo}, a);
        chk({r_acc, r_op}, {en, code});
        wr(1, 8'h00);
        wr(0, 8'h00);
    endtask
    task automatic rd(input flash_addr_t a, input flash_byte_t exp);
        op(8'h80, 8'h01, a, 8'h00, 8'h00);
        chk(r_data, exp);
    endtask
    task automatic boot(input logic po, input logic hw, input logic ext,
        input logic exp);
        @(posedge clk);
        hwopt <= hw;
        extopt <= ext;
        pob <= po;
        erb <= !po;
        @(posedge clk);
        pob <= 1'b0;
        erb <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(bootl, exp);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(r_data, 8'hFF);
        op(8'h80, 8'h03, 16'h0200, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b10);
        rd(16'h0201, 8'hFF);
        rd(16'h03FF, 8'hFF);
        op(8'h80, 8'h02, 16'h0201, 8'hA5, 8'h00);
        chk(irq_at, 4'h1);
        rd(16'h0201, 8'hA5);
        op(8'h80, 8'h02, 16'h0201, 8'h0F, 8'h00);
        rd(16'h0201, 8'h05);
        op(8'h80, 8'h03, 16'h0400, 8'h00, 8'h00);
        rd(16'h0201, 8'h05);
        $display("test flash operations done");
        op(8'h80, 8'h02, 16'hFE10, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b01);
        op(8'h80, 8'h01, 16'h0201, 8'h00, 8'h12);
        chk({seen_done, seen_rej}, 2'b00);
        op(8'h00, 8'h01, 16'h0201, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b00);
        op(8'h80, 8'h00, 16'h0201, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b00);
        op(8'h80, 8'h04, 16'h0201, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b00);
        @(posedge clk);
        runld <= 1'b0;
        op(8'h80, 8'h02, 16'h0201, 8'h00, 8'h00);
        chk({seen_done, seen_rej}, 2'b01);
        op(8'h80, 8'h02, 16'hF000, 8'h3C, 8'h00);
        chk({seen_done, seen_rej}, 2'b10);
        $display("test refusals done");
        for (int k = 0; k < 4; k++) begin
            lden <= (k != 3);
            wr(0, {k == 0 ? 3'h1 : k == 2 ? 3'h5 : 3'h7, 5'h00});
            seen = 1'b0;
            repeat (4) begin
                #1 seen |= (srst === 1'b1);
                @(posedge clk);
            end
            chk({seen, bootl}, {k != 3, k == 1});
        end
        lden <= 1'b1;
        $display("test software reset done");
        boot(1'b1, 1'b1, 1'b0, 1'b1);
        boot(1'b0, 1'b1, 1'b0, 1'b0);
        boot(1'b0, 1'b1, 1'b1, 1'b1);
        @(posedge clk);
        lden <= 1'b0;
        boot(1'b1, 1'b1, 1'b0, 1'b0);
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        $display("test boot source done");
        @(posedge clk);
        fetch <= 16'h0010;
        runld <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(phys, 16'hFE10);
        @(posedge clk);
        runld <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(phys, 16'h0010);
        $display("test fetch relocation done");
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        #40000;
        num_errors++;
        $display("watchdog expired at %0t", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
